// *** pcw_pkg.sv ***
// Purpose: Shared constants and types for the pad cell and wired logic block
// Assumes: Single 40 MHz clock domain
// Notes:   Function codes select the pad output stage operation
package pcw_pkg;
    localparam int unsigned PCW_CLK_HZ        = 40000000;
    localparam int unsigned PCW_EDGE_DEC      = 4;
    localparam int unsigned PCW_DEC_IN        = 42;
    localparam int unsigned PCW_ROW_VARS      = 3;
    localparam int unsigned PCW_MAX_DECODERS  = 32;
    localparam logic        PCW_INIT_RESET    = 1'b0;
    localparam logic        PCW_KEEP_RESET    = 1'b1;

    typedef enum logic [1:0] {
        PCW_FN_PASS,
        PCW_FN_AND,
        PCW_FN_OR,
        PCW_FN_XOR
    } pcw_fn_t;

    typedef enum logic [1:0] {
        PCW_DRV_STD,
        PCW_DRV_WAND,
        PCW_DRV_WORAND
    } pcw_drv_t;

    typedef enum logic [1:0] {
        PCW_PAD_PULLUP,
        PCW_PAD_PULLDOWN,
        PCW_PAD_DRIVEN,
        PCW_PAD_EXTERNAL
    } pcw_pad_t;
endpackage : pcw_pkg

// *** pcw_pad_wired.sv ***
// Purpose: Pad cell output stage, pad flip-flops, longline drivers with keeper, wide edge decoders
// Assumes: All pad clocks are modelled as per-flop edge selects sampled on one system clock
// Notes:   Pad-side inputs pass a two-stage synchroniser before any logic reads them
`timescale 1ns/1ps
module pcw_pad_wired
    import pcw_pkg::*;
#(
    parameter int unsigned N_CELLS = 4,
    parameter int unsigned N_ROWS  = 4,
    parameter int unsigned N_PADS  = 8
) (
    input  wire logic                   clock,
    input  wire logic                   arst_n,
    input  wire logic                   clk_en,
    input  wire logic                   configuring,
    input  wire logic                   global_set_clear,
    input  wire logic                   global_float,
    input  wire logic                   extest_active,
    // Pad output stage
    input  wire logic                   out_a,
    input  wire logic                   out_b,
    input  wire logic                   out_float,
    input  wire logic                   cfg_mux_mode,
    input  pcw_fn_t                     cfg_fn,
    input  wire logic                   cfg_inv_a,
    input  wire logic                   cfg_inv_b,
    input  wire logic                   cfg_use_oreg,
    input  wire logic                   cfg_inv_out,
    input  wire logic                   cfg_inv_float,
    input  wire logic                   cfg_init_set_o,
    input  wire logic                   cfg_init_set_i,
    // Pad clocks, sampled and edge detected
    input  wire logic                   out_clk_pin,
    input  wire logic                   in_clk_pin,
    input  wire logic                   early_clk_pin,
    input  wire logic                   cfg_inv_oclk,
    input  wire logic                   cfg_inv_iclk,
    input  wire logic                   cfg_early_to_o,
    input  wire logic                   cfg_early_to_i,
    input  wire logic                   pad_in_pin,
    input  pcw_pad_t                    cfg_pad_mode,
    // Longline drivers
    input  wire logic [2*N_CELLS-1:0]   drv_in0,
    input  wire logic [2*N_CELLS-1:0]   drv_in1,
    input  wire logic [2*N_CELLS-1:0]   drv_float,
    input  pcw_drv_t                    cfg_drv_mode,
    input  wire logic [1:0]             cfg_line_pullup,
    // Edge decoder
    input  wire logic [N_PADS-1:0]      dec_pad_in,
    input  wire logic [3*N_ROWS-1:0]    dec_row_in,
    input  wire logic [N_PADS+3*N_ROWS-1:0] cfg_dec_sel,
    input  wire logic [N_PADS+3*N_ROWS-1:0] cfg_dec_inv,
    input  wire logic                   cfg_dec_split,
    input  wire logic                   cfg_dec_to_pad,
    // Results
    output logic                        pad_out,
    output logic                        pad_out_en_n,
    output logic                        pad_pullup,
    output logic                        pad_pulldown,
    output logic                        in_reg_q,
    output logic [1:0]                  longline_q,
    output logic [1:0]                  dec_out_q,
    output logic                        dec_pad_q
);
    localparam int unsigned DW = N_PADS + 3 * N_ROWS;
    localparam int unsigned HW = DW / 2;

    // Two-flop synchronisers for every pin-side input
    logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q;
    logic [N_PADS-1:0] dpad_s1_q, dpad_s2_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_q  <= 4'h0;
            pin_s2_q  <= 4'h0;
            pin_s3_q  <= 4'h0;
            dpad_s1_q <= '0;
            dpad_s2_q <= '0;
        end else if (clk_en) begin
            pin_s1_q  <= {pad_in_pin, early_clk_pin, in_clk_pin, out_clk_pin};
            pin_s2_q  <= pin_s1_q;
            pin_s3_q  <= pin_s2_q;      // Delayed copy for edge detection
            dpad_s1_q <= dec_pad_in;
            dpad_s2_q <= dpad_s1_q;
        end
    end

    // Clock source select and inversion; early clock may feed either or both
    logic oclk_now, oclk_prev, iclk_now, iclk_prev, o_edge, i_edge;
    always_comb begin
        oclk_now  = (cfg_early_to_o ? pin_s2_q[2] : pin_s2_q[0]) ^ cfg_inv_oclk;
        oclk_prev = (cfg_early_to_o ? pin_s3_q[2] : pin_s3_q[0]) ^ cfg_inv_oclk;
        iclk_now  = (cfg_early_to_i ? pin_s2_q[2] : pin_s2_q[1]) ^ cfg_inv_iclk;
        iclk_prev = (cfg_early_to_i ? pin_s3_q[2] : pin_s3_q[1]) ^ cfg_inv_iclk;
        o_edge    = oclk_now & ~oclk_prev;
        i_edge    = iclk_now & ~iclk_prev;
    end

    // Output stage: mux or two-input function generator
    logic a_v, b_v, fn_v;
    always_comb begin
        a_v = out_a ^ cfg_inv_a;
        b_v = out_b ^ cfg_inv_b;
        if (cfg_mux_mode) begin
            fn_v = cfg_inv_a ? out_b : out_a;   // Select reuses inv_a as mux select
        end else begin
            case (cfg_fn)
                PCW_FN_PASS: fn_v = a_v;
                PCW_FN_AND:  fn_v = a_v & b_v;
                PCW_FN_OR:   fn_v = a_v | b_v;
                PCW_FN_XOR:  fn_v = a_v ^ b_v;
                default:     fn_v = a_v;
            endcase
        end
    end

    // Output flop: configuration or the global net loads its set value; async reset clears it
    logic out_reg_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            out_reg_q <= PCW_INIT_RESET;
        end else if (clk_en) begin
            if (configuring || global_set_clear) begin
                out_reg_q <= cfg_init_set_o;
            end else if (o_edge) begin
                out_reg_q <= fn_v;
            end
        end
    end

    // Input path: fast capture latch rides on the output clock edge
    logic fcl_q, in_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fcl_q <= PCW_INIT_RESET;
            in_q  <= PCW_INIT_RESET;
        end else if (clk_en) begin
            if (configuring || global_set_clear) begin
                fcl_q <= cfg_init_set_i;
                in_q  <= cfg_init_set_i;
            end else begin
                if (o_edge) begin
                    fcl_q <= pin_s2_q[3];
                end
                if (i_edge) begin
                    in_q <= cfg_early_to_o ? fcl_q : pin_s2_q[3];
                end
            end
        end
    end
    assign in_reg_q = in_q;

    // Pad drive, float and pull control, registered
    logic float_v;
    always_comb begin
        float_v = (out_float ^ cfg_inv_float)
                | (cfg_pad_mode != PCW_PAD_DRIVEN)
                | (global_float & ~extest_active);
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pad_out      <= 1'b0;
            pad_out_en_n <= 1'b1;
            pad_pullup   <= 1'b1;
            pad_pulldown <= 1'b0;
        end else if (clk_en) begin
            pad_out      <= (cfg_use_oreg ? out_reg_q : fn_v) ^ cfg_inv_out;
            pad_out_en_n <= configuring | float_v;
            pad_pullup   <= configuring | (cfg_pad_mode == PCW_PAD_PULLUP);
            pad_pulldown <= ~configuring & (cfg_pad_mode == PCW_PAD_PULLDOWN);
        end
    end

    // Longline drivers: even index drives line above, odd line below
    logic [1:0] any_low, any_high, any_drv;
    always_comb begin
        any_low  = 2'h0;
        any_high = 2'h0;
        for (int i = 0; i < int'(2 * N_CELLS); i++) begin
            case (cfg_drv_mode)
                PCW_DRV_STD: begin
                    if (!drv_float[i]) begin
                        any_low[i%2]  = any_low[i%2]  | ~drv_in0[i];
                        any_high[i%2] = any_high[i%2] |  drv_in0[i];
                    end
                end
                PCW_DRV_WAND: begin
                    any_low[i%2] = any_low[i%2] | ~drv_in0[i];
                end
                PCW_DRV_WORAND: begin
                    any_low[i%2] = any_low[i%2] | ~(drv_in0[i] | drv_in1[i]);
                end
                default: begin
                    any_low[i%2] = any_low[i%2];
                end
            endcase
        end
        any_drv = any_low | any_high | cfg_line_pullup;
    end

    // Resolution and keeper; contention resolves low, as in the wired-AND sense
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            longline_q <= {2{PCW_KEEP_RESET}};
        end else if (clk_en) begin
            for (int l = 0; l < 2; l++) begin
                if (any_low[l]) begin
                    longline_q[l] <= 1'b0;
                end else if (any_drv[l]) begin
                    longline_q[l] <= 1'b1;
                end
            end
        end
    end

    // Edge decoder: wired AND over selected true or complemented inputs
    logic [DW-1:0] dec_vec, dec_term;
    logic          dec_lo, dec_hi;
    always_comb begin
        dec_vec  = {dec_row_in, dpad_s2_q};
        dec_term = (dec_vec ^ cfg_dec_inv) | ~cfg_dec_sel;
        dec_lo   = &dec_term[HW-1:0];
        dec_hi   = &dec_term[DW-1:HW];
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dec_out_q <= 2'h3;
            dec_pad_q <= 1'b1;
        end else if (clk_en) begin
            if (cfg_dec_split) begin
                dec_out_q <= {dec_hi, dec_lo};
            end else begin
                dec_out_q <= {2{dec_lo & dec_hi}};
            end
            // A decoder not routed to a pad leaves the pad copy idling high,
            // the same level its pull-up would give an unrouted wired line
            if (cfg_dec_to_pad) begin
                dec_pad_q <= dec_lo & (cfg_dec_split | dec_hi);
            end else begin
                dec_pad_q <= 1'b1;
            end
        end
    end

    // Checks
    pcw_nodrv_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && !any_drv[0] |=> $stable(longline_q[0]))
        else $error("keeper lost level");
    pcw_lowwin_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && any_low[1] |=> !longline_q[1])
        else $error("low drive not seen");
    pcw_gsr_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && global_set_clear |=> out_reg_q == $past(cfg_init_set_o))
        else $error("set clear value wrong");
    pcw_gfloat_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && global_float && !extest_active |=> pad_out_en_n)
        else $error("global float ignored");
    pcw_cfgpu_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && configuring |=> pad_pullup && pad_out_en_n)
        else $error("config pull-up off");
    pcw_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && !o_edge && !global_set_clear && !configuring |=> $stable(out_reg_q))
        else $error("out flop moved without edge");
    pcw_wand_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && cfg_drv_mode == PCW_DRV_WAND && !drv_in0[0] |=> !longline_q[0])
        else $error("wired and failed");
    pcw_dec_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && !cfg_dec_split && cfg_dec_sel == '0 |=> dec_out_q == 2'h3)
        else $error("empty decoder not high");
    pcw_fn_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && !cfg_use_oreg |=> pad_out == ($past(fn_v) ^ $past(cfg_inv_out)))
        else $error("bypass path wrong");
    // Input flop must only move on its own edge, during configuration or on the global net
    pcw_inhold_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && !i_edge && !global_set_clear && !configuring |=> $stable(in_q))
        else $error("in flop moved without edge");
    // Any active driver or pull-up must beat the keeper
    pcw_override_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && any_drv[1] && !any_low[1] |=> longline_q[1])
        else $error("keeper not overridden");
    // Both OR-AND inputs low must pull the line down
    pcw_worand_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && cfg_drv_mode == PCW_DRV_WORAND && !drv_in0[1] && !drv_in1[1] |=> !longline_q[1])
        else $error("or-and low lost");
    // Default unused pad keeps its pull-up and never its pull-down
    pcw_pullup_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && !configuring && cfg_pad_mode == PCW_PAD_PULLUP |=> pad_pullup && !pad_pulldown)
        else $error("unused pad not pulled up");
    // Pull-down would fight the configuration pull-up
    pcw_cfgpd_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && configuring |=> !pad_pulldown)
        else $error("pull-down during config");
    // Split halves must report independently
    pcw_split_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && cfg_dec_split |=> dec_out_q == {$past(dec_hi), $past(dec_lo)})
        else $error("split decoder wrong");
    // Mux mode drives the pad from out_b when inv_a is set, else from out_a
    pcw_mux_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && cfg_mux_mode && !cfg_use_oreg && !cfg_inv_out
        |=> pad_out == ($past(cfg_inv_a) ? $past(out_b) : $past(out_a)))
        else $error("mux select wrong");

    pcw_split_c: cover property (@(posedge clock) disable iff (!arst_n) cfg_dec_split && dec_out_q == 2'h1);
    pcw_oedge_c: cover property (@(posedge clock) disable iff (!arst_n) clk_en && o_edge);
    pcw_keep_c:  cover property (@(posedge clock) disable iff (!arst_n) clk_en && any_drv == 2'h0);
    // Scenarios the bench is expected to reach: global pulse and wired-AND pull-down
    pcw_gsr_c:   cover property (@(posedge clock) disable iff (!arst_n) clk_en && global_set_clear);
    pcw_wand_c:  cover property (@(posedge clock) disable iff (!arst_n) clk_en && cfg_drv_mode == PCW_DRV_WAND
                                 && any_low[1]);
endmodule : pcw_pad_wired

// *** pcw_cell_model.sv ***
// Purpose: Logic cell side of the longlines: one chosen driver, all others released
// Assumes: Bench changes the selection on the falling clock edge
// Notes:   Released drivers sit high so they never pull a wired line low
`timescale 1ns/1ps
module pcw_cell_model
    import pcw_pkg::*;
#(
    parameter int unsigned N_CELLS = 4
) (
    input  wire logic                 sel_en,
    input  wire logic [2:0]           sel_idx,
    input  wire logic                 sel_d0,
    input  wire logic                 sel_d1,
    output logic      [2*N_CELLS-1:0] drv_in0,
    output logic      [2*N_CELLS-1:0] drv_in1,
    output logic      [2*N_CELLS-1:0] drv_float
);
    // Only the selected driver may ever have its float request low
    always_comb begin
        drv_in0            = '1;
        drv_in1            = '1;
        drv_float          = '1;
        drv_in0[sel_idx]   = sel_d0;
        drv_in1[sel_idx]   = sel_d1;
        drv_float[sel_idx] = ~sel_en;
    end
endmodule // pcw_cell_model

// *** pcw_pad_wired_tb.sv ***
// Purpose: Self-checking bench for the pad cell and wired logic block
// Assumes: Inputs change on the falling edge and are read one falling edge later
// Notes:   Pin inputs pass a synchroniser, so those checks wait six cycles
`timescale 1ns/1ps
module pcw_pad_wired_tb
    import pcw_pkg::*;
;
    logic       clock, arst_n, clk_en, configuring, global_set_clear, global_float, extest_active;
    logic       out_a, out_b, out_float, cfg_mux_mode, cfg_inv_a, cfg_inv_b, cfg_use_oreg, cfg_inv_out;
    logic       cfg_inv_float, cfg_init_set_o, cfg_init_set_i, out_clk_pin, in_clk_pin, early_clk_pin;
    logic       cfg_inv_oclk, cfg_inv_iclk, cfg_early_to_o, cfg_early_to_i, pad_in_pin;
    logic       cfg_dec_split, cfg_dec_to_pad, sel_en, sel_d0, sel_d1;
    logic       pad_out, pad_out_en_n, pad_pullup, pad_pulldown, in_reg_q, dec_pad_q;
    pcw_fn_t    cfg_fn;
    pcw_pad_t   cfg_pad_mode;
    pcw_drv_t   cfg_drv_mode;
    logic [1:0] cfg_line_pullup, longline_q, dec_out_q;
    logic [2:0] sel_idx;
    logic [7:0] drv_in0, drv_in1, drv_float, dec_pad_in;
    logic [11:0] dec_row_in;
    logic [19:0] cfg_dec_sel, cfg_dec_inv, m;
    int         err_count, total_checks;
    // Row: mux, fn[1:0], inv_a, inv_b, a, b, expected pad
    logic [7:0] rows [17] = '{8'h05, 8'h14, 8'h27, 8'h24, 8'h33, 8'h39, 8'h40, 8'h43, 8'h4A,
                              8'h5E, 8'h66, 8'h65, 8'h77, 8'h7D, 8'h85, 8'h94, 8'h93};
    // All true, low half false, high half false
    logic [19:0] vecs [3] = '{20'h08401, 20'h08403, 20'h00401};

    pcw_pad_wired #(.N_CELLS(4), .N_ROWS(4), .N_PADS(8)) DUT (
        .clock, .arst_n, .clk_en, .configuring, .global_set_clear, .global_float, .extest_active,
        .out_a, .out_b, .out_float, .cfg_mux_mode, .cfg_fn, .cfg_inv_a, .cfg_inv_b, .cfg_use_oreg,
        .cfg_inv_out, .cfg_inv_float, .cfg_init_set_o, .cfg_init_set_i, .out_clk_pin, .in_clk_pin,
        .early_clk_pin, .cfg_inv_oclk, .cfg_inv_iclk, .cfg_early_to_o, .cfg_early_to_i, .pad_in_pin,
        .cfg_pad_mode, .drv_in0, .drv_in1, .drv_float, .cfg_drv_mode, .cfg_line_pullup, .dec_pad_in,
        .dec_row_in, .cfg_dec_sel, .cfg_dec_inv, .cfg_dec_split, .cfg_dec_to_pad, .pad_out,
        .pad_out_en_n, .pad_pullup, .pad_pulldown, .in_reg_q, .longline_q, .dec_out_q, .dec_pad_q);

    pcw_cell_model #(.N_CELLS(4)) cells (.sel_en, .sel_idx, .sel_d0, .sel_d1, .drv_in0, .drv_in1,
                                         .drv_float);

    task automatic chk1(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk2(input string name, input logic [1:0] exp, input logic [1:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Single exit point for both the normal end and the watchdog
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Watchdog sized well past the hundred or so cycles the tests need
    initial begin
        #(25 * 4000);
        err_count++;
        tally_and_finish();
    end

    // Main sequence: table first, then hand-written cases
    initial begin
        {arst_n, configuring, global_set_clear, global_float, extest_active, out_float} = 6'h00;
        {cfg_inv_out, cfg_inv_float, cfg_init_set_o, cfg_init_set_i, cfg_use_oreg} = 5'h00;
        {out_clk_pin, in_clk_pin, early_clk_pin, cfg_inv_oclk, cfg_inv_iclk, pad_in_pin} = 6'h00;
        {cfg_early_to_o, cfg_early_to_i, cfg_dec_split, sel_en, sel_d0, sel_d1, sel_idx} = 9'h000;
        {clk_en, cfg_dec_to_pad, cfg_line_pullup, dec_pad_in, dec_row_in} = 24'hC00000;
        {cfg_dec_sel, cfg_dec_inv} = {20'h0C403, 20'h04002};
        cfg_fn = PCW_FN_PASS;
        cfg_pad_mode = PCW_PAD_DRIVEN;
        cfg_drv_mode = PCW_DRV_STD;
        err_count = 0;
        total_checks = 0;
        step(1);
        chk1("en_n rst", 1'h1, pad_out_en_n);
        chk1("pullup rst", 1'h1, pad_pullup);
        step(1);
        arst_n = 1'b1;
        foreach (rows[i]) begin
            cfg_fn = pcw_fn_t'(rows[i][6:5]);
            {cfg_mux_mode, cfg_inv_a, cfg_inv_b, out_a, out_b} = {rows[i][7], rows[i][4:1]};
            step(1);
            chk1("pad_out fn", rows[i][0], pad_out);
            chk1("en_n fn", 1'h0, pad_out_en_n);
        end
        // Polarity, float and pad mode; current row drives a 1
        cfg_inv_out = 1'b1;
        out_float = 1'b1;
        step(1);
        chk1("pad_out inv", 1'h0, pad_out);
        chk1("en_n float", 1'h1, pad_out_en_n);
        cfg_inv_float = 1'b1;
        step(1);
        chk1("en_n inv", 1'h0, pad_out_en_n);
        global_float = 1'b1;
        step(1);
        chk1("en_n global", 1'h1, pad_out_en_n);
        extest_active = 1'b1;
        step(1);
        chk1("en_n extest", 1'h0, pad_out_en_n);
        {global_float, extest_active, cfg_inv_out} = 3'h0;
        cfg_pad_mode = PCW_PAD_PULLUP;
        step(1);
        chk1("en_n unused", 1'h1, pad_out_en_n);
        chk1("pullup unused", 1'h1, pad_pullup);
        cfg_pad_mode = PCW_PAD_PULLDOWN;
        step(1);
        chk2("pulldown", 2'h1, {pad_pullup, pad_pulldown});
        cfg_pad_mode = PCW_PAD_DRIVEN;
        configuring = 1'b1;
        step(1);
        chk1("pullup config", 1'h1, pad_pullup);
        configuring = 1'b0;
        // Pad flops: set value on pulse, then pin-clocked capture
        cfg_fn = PCW_FN_PASS;
        {cfg_mux_mode, cfg_inv_a, out_a, cfg_use_oreg} = 4'h1;
        {cfg_init_set_o, cfg_init_set_i, global_set_clear} = 3'h7;
        step(1);
        global_set_clear = 1'b0;
        step(2);
        chk2("set flops", 2'h3, {pad_out, in_reg_q});
        {out_clk_pin, in_clk_pin} = 2'h3;
        step(6);
        chk2("rise capture", 2'h0, {pad_out, in_reg_q});
        {out_a, cfg_inv_oclk} = 2'h3;
        step(6);
        chk1("inv no capture", 1'h0, pad_out);
        out_clk_pin = 1'b0;
        step(6);
        chk1("fall capture", 1'h1, pad_out);
        {cfg_early_to_i, pad_in_pin, in_clk_pin} = 3'h6;
        step(6);
        in_clk_pin = 1'b1;
        step(6);
        chk1("early idle", 1'h0, in_reg_q);
        early_clk_pin = 1'b1;
        step(6);
        chk1("early capture", 1'h1, in_reg_q);
        // Longlines driven by the cell model
        {sel_idx, sel_en, sel_d0} = 5'h03;
        step(1);
        chk2("line std", 2'h3, longline_q);
        {sel_idx, sel_d0} = 4'h2;
        step(1);
        chk2("line keep", 2'h1, longline_q);
        {sel_en, sel_d0} = 2'h1;
        step(1);
        chk2("line float", 2'h1, longline_q);
        {cfg_line_pullup, sel_idx, sel_en, sel_d0} = 7'h64;
        cfg_drv_mode = PCW_DRV_WAND;
        step(1);
        chk2("wand low", 2'h1, longline_q);
        sel_d0 = 1'b1;
        step(1);
        chk2("wand high", 2'h3, longline_q);
        {sel_idx, sel_d0, sel_d1} = 5'h0D;
        cfg_drv_mode = PCW_DRV_WORAND;
        step(1);
        chk2("worand off", 2'h3, longline_q);
        sel_d1 = 1'b0;
        step(1);
        chk2("worand low", 2'h1, longline_q);
        // Clock enable low freezes the line although the driver lets go
        clk_en = 1'b0;
        sel_d1 = 1'b1;
        step(1);
        chk2("line frozen", 2'h1, longline_q);
        clk_en = 1'b1;
        step(1);
        chk2("line resumed", 2'h3, longline_q);
        // Edge decoder, whole then split
        for (int s = 0; s < 2; s++) begin
            cfg_dec_split = s[0];
            foreach (vecs[i]) begin
                {dec_row_in, dec_pad_in} = vecs[i];
                m = ~cfg_dec_sel | (vecs[i] ^ cfg_dec_inv);
                step(4);
                if (s == 0) begin
                    chk1("dec whole", &m, dec_pad_q);
                    chk2("dec whole out", {2{&m}}, dec_out_q);
                end else begin
                    chk2("dec split", {&m[19:10], &m[9:0]}, dec_out_q);
                end
            end
        end
        tally_and_finish();
    end
endmodule // pcw_pad_wired_tb
